// ==== core/brk_pkg.sv ====
package brk_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_W  = 8;
  localparam int REG_AW = 3;

  // register indices on the plain register port
  localparam logic [REG_AW-1:0] OFS_CTRL    = 3'h0;
  localparam logic [REG_AW-1:0] OFS_STAT    = 3'h1;
  localparam logic [REG_AW-1:0] OFS_ADDR_HI = 3'h2;
  localparam logic [REG_AW-1:0] OFS_ADDR_LO = 3'h3;
  localparam logic [REG_AW-1:0] OFS_DATA_HI = 3'h4;
  localparam logic [REG_AW-1:0] OFS_DATA_LO = 3'h5;

  // status register layout
  localparam int STAT_FLAG_BIT = 7;
  localparam int STAT_IE_BIT   = 6;
  localparam logic [REG_W-1:0] STAT_RSVD_ONES = 8'h3f;

  // reset values
  localparam logic [REG_W-1:0]  CTRL_RESET = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'hffff;
  localparam logic [REG_W-1:0]  READ_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    CYC_EXEC  = 2'h0,
    CYC_READ  = 2'h1,
    CYC_WRITE = 2'h2,
    CYC_RW    = 2'h3
  } cycle_sel_t;

  typedef enum logic [2:0] {
    AW_16 = 3'h0,
    AW_12 = 3'h1,
    AW_8  = 3'h2,
    AW_4  = 3'h3
  } addr_width_t;

  typedef enum logic [1:0] {
    DS_NONE = 2'h0,
    DS_LOW  = 2'h1,
    DS_HIGH = 2'h2,
    DS_FULL = 2'h3
  } data_sel_t;

  // bit 7 unmask, 6:5 cycle, 4:2 address width, 1:0 data select
  typedef struct packed {
    logic        return_irq_unmask;
    cycle_sel_t  cycle_select;
    addr_width_t address_match_width;
    data_sel_t   data_match_select;
  } ctrl_t;

  typedef struct packed {
    logic              valid;
    logic              exec;
    logic              write;
    logic              word;
    logic              io8;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cpu_bus_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } reg_req_t;

  function automatic logic [ADDR_W-1:0] addr_mask(input addr_width_t w);
    case (w)
      AW_16:   addr_mask = 16'hffff;
      AW_12:   addr_mask = 16'hfff0;
      AW_8:    addr_mask = 16'hff00;
      AW_4:    addr_mask = 16'hf000;
      default: addr_mask = 16'hffff;
    endcase
  endfunction

endpackage

// ==== core/break_match.sv ====
`timescale 1ns/10ps
module break_match (
  input  wire brk_pkg::ctrl_t          ctrl,
  input  wire logic [brk_pkg::ADDR_W-1:0] bar,
  input  wire logic [brk_pkg::DATA_W-1:0] bdata,
  input  wire brk_pkg::cpu_bus_t       bus,
  output logic                         hit
);

  logic                         cyc_ok;
  logic                         addr_ok;
  logic                         data_ok;
  logic                         upper_only;
  logic [brk_pkg::DATA_W-1:0]   lanes;
  logic [brk_pkg::ADDR_W-1:0]   msk;

  always_comb begin
    // byte and 8-bit i/o accesses ride the upper lane
    upper_only = !bus.word || bus.io8;                   // see RULE7
    if (upper_only) begin
      lanes = {bus.data[7:0], 8'h00};                    // see RULE8
    end else if (bus.addr[0]) begin
      lanes = {8'h00, bus.data[7:0]};                    // see RULE9
    end else begin
      lanes = bus.data;                                  // see RULE9
    end
    case (ctrl.cycle_select)                             // see RULE3
      brk_pkg::CYC_EXEC:  cyc_ok = bus.exec;
      brk_pkg::CYC_READ:  cyc_ok = !bus.exec && !bus.write;
      brk_pkg::CYC_WRITE: cyc_ok = !bus.exec && bus.write;
      default:            cyc_ok = !bus.exec;
    endcase
    msk     = brk_pkg::addr_mask(ctrl.address_match_width); // see RULE4
    addr_ok = ((bus.addr ^ bar) & msk) == '0;
    case (ctrl.data_match_select)                        // see RULE6
      brk_pkg::DS_NONE: data_ok = 1'b1;
      brk_pkg::DS_LOW:  data_ok = lanes[7:0] == bdata[7:0];   // see RULE16
      brk_pkg::DS_HIGH: data_ok = lanes[15:8] == bdata[15:8]; // see RULE16
      default:          data_ok = lanes == bdata;
    endcase
    // an exec cycle has no data phase worth comparing
    if (bus.exec) begin
      data_ok = 1'b1;
    end
    hit = bus.valid && cyc_ok && addr_ok && data_ok;     // see RULE21
  end

endmodule

// ==== core/rte_gate.sv ====
`timescale 1ns/10ps
module return_gate (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic unmask,
  input  wire logic return_done,
  input  wire logic insn_done,
  output logic      hold
);

  typedef struct packed {
    logic hold;
  } gate_st_t;

  gate_st_t st_ff;
  gate_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // the instruction after the return must finish before release
    if (return_done) begin
      nxt_st.hold = !unmask;                             // see RULE2
    end else if (insn_done) begin
      nxt_st.hold = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hold = st_ff.hold;

endmodule

// ==== core/address_break_comparator.sv ====
`timescale 1ns/10ps
// What this block does
// RULE1 - break request ignores cpu interrupt mask bit
// RULE2 - unmask bit 0 holds irq after return
// RULE3 - cycle select picks exec, read, write, either
// RULE4 - match width compares 16, 12, 8, 4 bits
// RULE5 - software never writes reserved width codes
// RULE6 - data select: none, low, high, full
// RULE7 - word to 8-bit i/o seen as bytes
// RULE8 - byte accesses always use upper lane
// RULE9 - word lane follows address parity and space
// RULE10 - flag sets when all conditions match
// RULE11 - flag clears by write 0 after read
// RULE12 - irq enable gates request forwarding
// RULE13 - six low status bits read one
// RULE14 - break address 16 bits, resets all ones
// RULE15 - software loads first byte of instruction
// RULE16 - data high vs upper lane, low vs lower
// RULE17 - software puts byte compare value in high
// RULE18 - break data register not reset
// RULE19 - request only while flag and enable set
// RULE20 - cpu takes exception after current instruction
// RULE21 - cycle, address, data matched same cycle
module address_break_comparator (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire brk_pkg::reg_req_t       reg_req,
  output logic [brk_pkg::REG_W-1:0]    reg_rdata,
  input  wire brk_pkg::cpu_bus_t       cpu_bus,
  input  wire logic                    return_done,
  input  wire logic                    insn_done,
  output logic                         break_irq
);

  typedef struct packed {
    brk_pkg::ctrl_t             ctrl;
    logic                       flag;
    logic                       ie;
    logic                       flag_seen;
    logic [brk_pkg::ADDR_W-1:0] bar;
    logic [brk_pkg::DATA_W-1:0] bdata;
    logic [brk_pkg::REG_W-1:0]  rdata;
  } brk_st_t;

  brk_st_t st_ff;
  brk_st_t nxt_st;

  logic                      hit;
  logic                      return_hold;
  logic                      clr_req;
  logic [brk_pkg::REG_W-1:0] stat_val;

  break_match u_match (
    .ctrl (st_ff.ctrl),
    .bar  (st_ff.bar),
    .bdata (st_ff.bdata),
    .bus  (cpu_bus),
    .hit  (hit)
  );

  return_gate u_ret (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .unmask      (st_ff.ctrl.return_irq_unmask),
    .return_done (return_done),
    .insn_done   (insn_done),
    .hold        (return_hold)
  );

  function automatic logic is_wr(input brk_pkg::reg_req_t r,
                                 input logic [brk_pkg::REG_AW-1:0] ofs);
    is_wr = r.wr && (r.addr == ofs);
  endfunction

  always_comb begin
    stat_val = brk_pkg::STAT_RSVD_ONES;                  // see RULE13
    stat_val[brk_pkg::STAT_FLAG_BIT] = st_ff.flag;
    stat_val[brk_pkg::STAT_IE_BIT]   = st_ff.ie;
  end

  // clear needs a prior read of the flag as one
  assign clr_req = is_wr(reg_req, brk_pkg::OFS_STAT) &&
                   !reg_req.wdata[brk_pkg::STAT_FLAG_BIT] &&
                   st_ff.flag_seen;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = brk_pkg::READ_ZERO;
    if (reg_req.rd) begin
      case (reg_req.addr)
        brk_pkg::OFS_CTRL:    nxt_st.rdata = st_ff.ctrl;
        brk_pkg::OFS_STAT:    nxt_st.rdata = stat_val;
        brk_pkg::OFS_ADDR_HI: nxt_st.rdata = st_ff.bar[15:8];
        brk_pkg::OFS_ADDR_LO: nxt_st.rdata = st_ff.bar[7:0];
        brk_pkg::OFS_DATA_HI: nxt_st.rdata = st_ff.bdata[15:8];
        brk_pkg::OFS_DATA_LO: nxt_st.rdata = st_ff.bdata[7:0];
        default:              nxt_st.rdata = brk_pkg::READ_ZERO;
      endcase
      if (reg_req.addr == brk_pkg::OFS_STAT && st_ff.flag) begin
        nxt_st.flag_seen = 1'b1;                         // see RULE11
      end
    end
    if (is_wr(reg_req, brk_pkg::OFS_CTRL)) begin
      nxt_st.ctrl = reg_req.wdata;                       // see RULE3
    end
    if (is_wr(reg_req, brk_pkg::OFS_STAT)) begin
      nxt_st.ie = reg_req.wdata[brk_pkg::STAT_IE_BIT];   // see RULE12
      if (clr_req) begin
        nxt_st.flag      = 1'b0;                         // see RULE11
        nxt_st.flag_seen = 1'b0;
      end
    end
    if (is_wr(reg_req, brk_pkg::OFS_ADDR_HI)) begin
      nxt_st.bar[15:8] = reg_req.wdata;                  // see RULE14
    end
    if (is_wr(reg_req, brk_pkg::OFS_ADDR_LO)) begin
      nxt_st.bar[7:0] = reg_req.wdata;                   // see RULE14
    end
    if (is_wr(reg_req, brk_pkg::OFS_DATA_HI)) begin
      nxt_st.bdata[15:8] = reg_req.wdata;                // see RULE16
    end
    if (is_wr(reg_req, brk_pkg::OFS_DATA_LO)) begin
      nxt_st.bdata[7:0] = reg_req.wdata;                 // see RULE16
    end
    // a match in the clearing cycle wins over the clear
    if (hit) begin
      nxt_st.flag = 1'b1;                                // see RULE10
    end
  end

  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
    // break data left out of reset on purpose
    if (!resetn) begin                                   // see RULE18
      st_ff.ctrl      <= brk_pkg::CTRL_RESET;            // see RULE2
      st_ff.flag      <= 1'b0;
      st_ff.ie        <= 1'b0;
      st_ff.flag_seen <= 1'b0;
      st_ff.bar       <= brk_pkg::ADDR_RESET;            // see RULE14
      st_ff.rdata     <= brk_pkg::READ_ZERO;
    end
  end

  assign reg_rdata = st_ff.rdata;

  // no cpu mask bit input: the request is not maskable by it
  assign break_irq = st_ff.flag && st_ff.ie &&
                     !return_hold;                       // see RULE1 RULE19

  // ---------------------------------------------------------------
  // assertions

  sequence stat_read_one_s;
    reg_req.rd && reg_req.addr == brk_pkg::OFS_STAT && st_ff.flag;
  endsequence

  sequence clear_write_s;
    reg_req.wr && reg_req.addr == brk_pkg::OFS_STAT &&
    !reg_req.wdata[brk_pkg::STAT_FLAG_BIT] && !hit;
  endsequence

  sequence return_masked_s;
    return_done && !st_ff.ctrl.return_irq_unmask;
  endsequence

  flag_sets_a: assert property (                         // see RULE10
    @(posedge ref_clk) disable iff (!resetn)
    hit |=> st_ff.flag)
    else $error("match did not set break flag");

  flag_clear_a: assert property (                        // see RULE11
    @(posedge ref_clk) disable iff (!resetn)
    stat_read_one_s ##1 (!reg_req.rd && !reg_req.wr && !hit) ##1
    clear_write_s
    |=> !st_ff.flag)
    else $error("flag not cleared after read then write zero");

  flag_keep_a: assert property (                         // see RULE11
    @(posedge ref_clk) disable iff (!resetn)
    st_ff.flag && !st_ff.flag_seen && reg_req.wr |=> st_ff.flag)
    else $error("flag cleared without a prior read");

  irq_gate_a: assert property (                          // see RULE19
    @(posedge ref_clk) disable iff (!resetn)
    break_irq |-> st_ff.flag && st_ff.ie)
    else $error("break irq raised without flag and enable");

  irq_fwd_a: assert property (                           // see RULE12
    @(posedge ref_clk) disable iff (!resetn)
    st_ff.flag && st_ff.ie && !return_hold |-> break_irq)
    else $error("enabled break not forwarded");

  return_hold_a: assert property (                       // see RULE2
    @(posedge ref_clk) disable iff (!resetn)
    return_masked_s ##1 (!insn_done && !return_done) |-> !break_irq)
    else $error("irq not held after return");

  return_free_a: assert property (                       // see RULE2
    @(posedge ref_clk) disable iff (!resetn)
    return_done && st_ff.ctrl.return_irq_unmask |=> !return_hold)
    else $error("irq held while unmask bit set");

  stat_ones_a: assert property (                         // see RULE13
    @(posedge ref_clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr == brk_pkg::OFS_STAT |=>
    reg_rdata[5:0] == brk_pkg::STAT_RSVD_ONES[5:0])
    else $error("reserved status bits not read as one");

  bar_reset_a: assert property (                         // see RULE14
    @(posedge ref_clk)
    !resetn |=> st_ff.bar == brk_pkg::ADDR_RESET)
    else $error("break address not all ones after reset");

  ctrl_reset_a: assert property (                        // see RULE2
    @(posedge ref_clk)
    !resetn |=> st_ff.ctrl == brk_pkg::CTRL_RESET)
    else $error("control register wrong after reset");

  read_back_a: assert property (                         // see RULE14
    @(posedge ref_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == brk_pkg::OFS_ADDR_LO ##1 !reg_req.wr ##1
    reg_req.rd && reg_req.addr == brk_pkg::OFS_ADDR_LO
    |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("break address low read back mismatch");

  exec_match_a: assert property (                        // see RULE3
    @(posedge ref_clk) disable iff (!resetn)
    cpu_bus.valid && !cpu_bus.exec &&
    st_ff.ctrl.cycle_select == brk_pkg::CYC_EXEC |-> !hit)
    else $error("data cycle matched an execution break");

  addr_mask_a: assert property (                         // see RULE4
    @(posedge ref_clk) disable iff (!resetn)
    hit |-> ((cpu_bus.addr ^ st_ff.bar) &
    brk_pkg::addr_mask(st_ff.ctrl.address_match_width)) == '0)
    else $error("hit with masked address mismatch");

  byte_lane_a: assert property (                         // see RULE8
    @(posedge ref_clk) disable iff (!resetn)
    hit && !cpu_bus.exec && !cpu_bus.word &&
    st_ff.ctrl.data_match_select == brk_pkg::DS_HIGH
    |-> cpu_bus.data[7:0] == st_ff.bdata[15:8])
    else $error("byte access compared on wrong lane");

  set_wins_a: assert property (                          // see RULE10
    @(posedge ref_clk) disable iff (!resetn)
    hit && clr_req |=> st_ff.flag)
    else $error("clear won over a simultaneous match");

  irq_reset_a: assert property (                         // see RULE19
    @(posedge ref_clk)
    !resetn |=> !break_irq)
    else $error("break irq high after reset");

  flag_reset_a: assert property (                        // see RULE10
    @(posedge ref_clk)
    !resetn |=> !st_ff.flag && !st_ff.ie)
    else $error("flag or enable set after reset");

  ie_write_a: assert property (                          // see RULE12
    @(posedge ref_clk) disable iff (!resetn)
    is_wr(reg_req, brk_pkg::OFS_STAT) |=>
    st_ff.ie == $past(reg_req.wdata[brk_pkg::STAT_IE_BIT]))
    else $error("irq enable not written");

  irq_off_a: assert property (                           // see RULE12
    @(posedge ref_clk) disable iff (!resetn)
    !st_ff.ie |-> !break_irq)
    else $error("break irq forwarded while disabled");

  flag_hold_a: assert property (                         // see RULE11
    @(posedge ref_clk) disable iff (!resetn)
    st_ff.flag && !is_wr(reg_req, brk_pkg::OFS_STAT) |=> st_ff.flag)
    else $error("flag dropped without a status write");

  flag_rise_a: assert property (                         // see RULE10
    @(posedge ref_clk) disable iff (!resetn)
    !st_ff.flag && !hit |=> !st_ff.flag)
    else $error("flag set without a match");

  arm_read_a: assert property (                          // see RULE11
    @(posedge ref_clk) disable iff (!resetn)
    stat_read_one_s |=> st_ff.flag_seen)
    else $error("read of a set flag did not arm the clear");

  stat_read_a: assert property (                         // see RULE10
    @(posedge ref_clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr == brk_pkg::OFS_STAT |=>
    reg_rdata[brk_pkg::STAT_FLAG_BIT] == $past(st_ff.flag))
    else $error("status read does not show the flag");

  bar_high_a: assert property (                          // see RULE14
    @(posedge ref_clk) disable iff (!resetn)
    is_wr(reg_req, brk_pkg::OFS_ADDR_HI) |=>
    st_ff.bar[15:8] == $past(reg_req.wdata))
    else $error("break address high not written");

  bar_low_a: assert property (                           // see RULE14
    @(posedge ref_clk) disable iff (!resetn)
    is_wr(reg_req, brk_pkg::OFS_ADDR_LO) |=>
    st_ff.bar[7:0] == $past(reg_req.wdata))
    else $error("break address low not written");

  data_high_a: assert property (                         // see RULE16
    @(posedge ref_clk) disable iff (!resetn)
    is_wr(reg_req, brk_pkg::OFS_DATA_HI) |=>
    st_ff.bdata[15:8] == $past(reg_req.wdata))
    else $error("break data high not written");

  ctrl_write_a: assert property (                        // see RULE3
    @(posedge ref_clk) disable iff (!resetn)
    is_wr(reg_req, brk_pkg::OFS_CTRL) |=>
    st_ff.ctrl == $past(reg_req.wdata))
    else $error("control register not written");

  write_miss_a: assert property (                        // see RULE3
    @(posedge ref_clk) disable iff (!resetn)
    cpu_bus.valid && cpu_bus.write &&
    st_ff.ctrl.cycle_select == brk_pkg::CYC_READ |-> !hit)
    else $error("write cycle matched a read break");

  read_miss_a: assert property (                         // see RULE3
    @(posedge ref_clk) disable iff (!resetn)
    cpu_bus.valid && !cpu_bus.exec && !cpu_bus.write &&
    st_ff.ctrl.cycle_select == brk_pkg::CYC_WRITE |-> !hit)
    else $error("read cycle matched a write break");

  data_full_a: assert property (                         // see RULE6
    @(posedge ref_clk) disable iff (!resetn)
    hit && !cpu_bus.exec && cpu_bus.word && !cpu_bus.io8 &&
    !cpu_bus.addr[0] && st_ff.ctrl.data_match_select == brk_pkg::DS_FULL
    |-> cpu_bus.data == st_ff.bdata)
    else $error("full compare hit with data mismatch");

  word_odd_a: assert property (                          // see RULE9
    @(posedge ref_clk) disable iff (!resetn)
    hit && !cpu_bus.exec && cpu_bus.word && !cpu_bus.io8 &&
    cpu_bus.addr[0] && st_ff.ctrl.data_match_select == brk_pkg::DS_LOW
    |-> cpu_bus.data[7:0] == st_ff.bdata[7:0])
    else $error("odd word access compared on wrong lane");

  return_release_a: assert property (                    // see RULE2
    @(posedge ref_clk) disable iff (!resetn)
    return_hold && insn_done && !return_done |=> !return_hold)
    else $error("hold not released after next instruction");

  nohit_idle_a: assert property (                        // see RULE21
    @(posedge ref_clk) disable iff (!resetn)
    !cpu_bus.valid |-> !hit)
    else $error("match raised without a bus cycle");

endmodule

// ==== dv/cpu_bus_model.sv ====
`timescale 1ns/10ps
module cpu_bus_model (
  input  wire logic         ref_clk,
  output brk_pkg::cpu_bus_t cpu_bus,
  output logic              return_done,
  output logic              insn_done
);
  initial begin
    cpu_bus = '0;
    return_done = 1'b0;
    insn_done = 1'b0;
  end

  // idle lines flip so a stale value never looks like a live cycle
  task automatic cycle(input logic ex, input logic wr, input logic wd,
                       input logic io, input logic [15:0] a,
                       input logic [15:0] d);
    @(posedge ref_clk);
    cpu_bus <= '{valid:1'b1, exec:ex, write:wr, word:wd, io8:io,
                 addr:a, data:d};
    @(posedge ref_clk);
    cpu_bus <= '{valid:1'b0, exec:~ex, write:~wr, word:~wd, io8:~io,
                 addr:~a, data:~d};
  endtask

  // word to a narrow i/o register leaves as two byte cycles
  task automatic io8_word(input logic wr, input logic [15:0] a,
                          input logic [15:0] d);
    cycle(1'b0, wr, 1'b0, 1'b1, a, {8'h00, d[15:8]});
    cycle(1'b0, wr, 1'b0, 1'b1, a + 16'h1, {8'h00, d[7:0]});
  endtask

  // exception entry itself is not modelled, only the completion pulses
  task automatic pulse(input logic ret);
    @(posedge ref_clk);
    if (ret) begin
      return_done <= 1'b1;
    end else begin
      insn_done <= 1'b1;
    end
    @(posedge ref_clk);
    return_done <= 1'b0;
    insn_done <= 1'b0;
  endtask
endmodule

// ==== dv/address_break_comparator_tb.sv ====
`timescale 1ns/10ps
module address_break_comparator_tb;
  logic              ref_clk;
  logic              resetn;
  logic              return_done;
  logic              insn_done;
  logic              break_irq;
  logic [7:0]        reg_rdata;
  logic [7:0]        rv;
  brk_pkg::reg_req_t reg_req;
  brk_pkg::cpu_bus_t cpu_bus;
  int                bad_count;
  int                n_tests;

  address_break_comparator address_break_comparator_inst (
    .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .cpu_bus(cpu_bus), .return_done(return_done),
    .insn_done(insn_done), .break_irq(break_irq));
  cpu_bus_model cpu_bus_model_inst (
    .ref_clk(ref_clk), .cpu_bus(cpu_bus), .return_done(return_done),
    .insn_done(insn_done));

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  task automatic expect_reg(input string what, input logic [2:0] a,
                            input logic [7:0] exp);
    @(posedge ref_clk);
    reg_req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 rv = reg_rdata;
    check(what, {8'h00, exp}, {8'h00, rv});
  endtask

  task automatic setup(input logic [7:0] c, input logic [15:0] a,
                       input logic [15:0] d);
    wr_reg(brk_pkg::OFS_CTRL, c);
    wr_reg(brk_pkg::OFS_ADDR_HI, a[15:8]);
    wr_reg(brk_pkg::OFS_ADDR_LO, a[7:0]);
    wr_reg(brk_pkg::OFS_DATA_HI, d[15:8]);
    wr_reg(brk_pkg::OFS_DATA_LO, d[7:0]);
  endtask

  // flag seen through irq and status, then cleared by read then write 0
  task automatic hit_check(input string what, input logic exp);
    #1 check({what, " irq"}, {15'h0, exp}, {15'h0, break_irq});
    expect_reg(what, brk_pkg::OFS_STAT, {exp, 7'h7f});
    wr_reg(brk_pkg::OFS_STAT, 8'h40);
  endtask

  task automatic lane(input logic [1:0] ds, input logic wd, input logic io,
                      input logic [15:0] a, input logic [15:0] d,
                      input logic exp);
    wr_reg(brk_pkg::OFS_CTRL, {1'b1, 2'h3, 3'h3, ds});
    cpu_bus_model_inst.cycle(1'b0, 1'b1, wd, io, a, d);
    hit_check("lane", exp);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    n_tests = 0;
    resetn = 1'b0;
    reg_req = '0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    expect_reg("ctrl rst", brk_pkg::OFS_CTRL, 8'h80);
    expect_reg("stat rst", brk_pkg::OFS_STAT, 8'h3f);
    expect_reg("bar hi rst", brk_pkg::OFS_ADDR_HI, 8'hff);
    expect_reg("bar lo rst", brk_pkg::OFS_ADDR_LO, 8'hff);
    expect_reg("unmapped", 3'h6, 8'h00);
    wr_reg(brk_pkg::OFS_STAT, 8'h40);
    expect_reg("stat low bits", brk_pkg::OFS_STAT, 8'h7f);
    setup(8'h80, 16'h1234, 16'habcd);
    expect_reg("bar hi", brk_pkg::OFS_ADDR_HI, 8'h12);
    wr_reg(brk_pkg::OFS_ADDR_LO, 8'h34);
    expect_reg("bar lo", brk_pkg::OFS_ADDR_LO, 8'h34);
    expect_reg("bdata lo", brk_pkg::OFS_DATA_LO, 8'hcd);
    end_test("registers");

    for (int cs = 0; cs < 4; cs++) begin
      wr_reg(brk_pkg::OFS_CTRL, {1'b1, 2'(cs), 5'h00});
      for (int k = 0; k < 3; k++) begin
        cpu_bus_model_inst.cycle(k == 0, k == 2, 1'b1, 1'b0, 16'h1234,
                                 16'h0);
        hit_check("cycle", cs == 0 ? k == 0 : cs == 3 ? k != 0 : cs == k);
      end
    end
    wr_reg(brk_pkg::OFS_CTRL, 8'h80);
    cpu_bus_model_inst.cycle(1'b1, 1'b0, 1'b1, 1'b0, 16'h1235, 16'h0);
    hit_check("addr miss", 1'b0);
    end_test("cycle select");

    // reserved width codes are never written
    for (int w = 0; w < 4; w++) begin
      wr_reg(brk_pkg::OFS_CTRL, {1'b1, 2'h1, 3'(w), 2'h0});
      expect_reg("ctrl", brk_pkg::OFS_CTRL, {1'b1, 2'h1, 3'(w), 2'h0});
      cpu_bus_model_inst.cycle(1'b0, 1'b0, 1'b1, 1'b0,
                               16'h1234 ^ ~(16'hffff << (4 * w)), 16'h0);
      hit_check("width hit", 1'b1);
      cpu_bus_model_inst.cycle(1'b0, 1'b0, 1'b1, 1'b0,
                               16'h1234 ^ (16'h1 << (4 * w)), 16'h0);
      hit_check("width miss", 1'b0);
    end
    end_test("address width");

    lane(2'h0, 1'b1, 1'b0, 16'h1234, 16'h0000, 1'b1);
    lane(2'h2, 1'b0, 1'b0, 16'h1234, 16'h00ab, 1'b1);
    lane(2'h2, 1'b0, 1'b0, 16'h1235, 16'h00ab, 1'b1);
    lane(2'h2, 1'b0, 1'b0, 16'h1235, 16'h00cd, 1'b0);
    lane(2'h1, 1'b1, 1'b0, 16'h1235, 16'h00cd, 1'b1);
    lane(2'h2, 1'b1, 1'b1, 16'h1235, 16'h00ab, 1'b1);
    lane(2'h3, 1'b1, 1'b0, 16'h1234, 16'habcd, 1'b1);
    lane(2'h3, 1'b1, 1'b0, 16'h1234, 16'habce, 1'b0);
    wr_reg(brk_pkg::OFS_CTRL, 8'hee);
    cpu_bus_model_inst.io8_word(1'b1, 16'h1234, 16'h55ab);
    hit_check("io8 word", 1'b1);
    end_test("data lanes");

    wr_reg(brk_pkg::OFS_STAT, 8'h00);
    cpu_bus_model_inst.cycle(1'b0, 1'b1, 1'b1, 1'b0, 16'h1234, 16'habcd);
    #1 check("irq off", 16'h0, {15'h0, break_irq});
    wr_reg(brk_pkg::OFS_STAT, 8'h40);
    #1 check("irq on", 16'h1, {15'h0, break_irq});
    expect_reg("no clear", brk_pkg::OFS_STAT, 8'hff);
    wr_reg(brk_pkg::OFS_STAT, 8'h40);
    expect_reg("cleared", brk_pkg::OFS_STAT, 8'h7f);
    end_test("flag clear");

    wr_reg(brk_pkg::OFS_CTRL, 8'h40);
    cpu_bus_model_inst.cycle(1'b0, 1'b1, 1'b1, 1'b0, 16'h1234, 16'h0);
    cpu_bus_model_inst.pulse(1'b1);
    #1 check("return hold", 16'h0, {15'h0, break_irq});
    repeat (3) @(posedge ref_clk);
    #1 check("return wait", 16'h0, {15'h0, break_irq});
    cpu_bus_model_inst.pulse(1'b0);
    @(posedge ref_clk);
    #1 check("return free", 16'h1, {15'h0, break_irq});
    wr_reg(brk_pkg::OFS_CTRL, 8'hc0);
    cpu_bus_model_inst.pulse(1'b1);
    #1 check("return unmask", 16'h1, {15'h0, break_irq});
    end_test("return hold");
    complete_run();
  end
endmodule
